// *** dv/adc_serial_readout_control_tb_top.sv ***
// Testbench joining the converter and its controller.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_readout_control_tb_top;
	logic               hclk;
	logic               hresetn;
	logic               hsel;
	logic               hwrite;
	logic               hreadyout;
	logic               hresp;
	logic               rd_chk;
	logic               sbc_q;
	logic [1:0]         htrans;
	logic [2:0]         hsize;
	logic [31:0]        haddr;
	logic [31:0]        hwdata;
	logic [31:0]        hrdata;
	logic [31:0]        rd;
	logic [31:0]        exp_q[$];
	logic signed [15:0] analog_level;
	logic signed [15:0] lvl[7];
	int                 n_fail;
	int                 compares;
	int                 pulses;

	asr_if i_asr_if ();

	asr_device i_asr_device (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.analog_level (analog_level),
		.pins         (i_asr_if)
	);
	asr_host i_asr_host (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .pins(i_asr_if)
	);
	asr_chk i_asr_chk (
		.hclk(hclk), .hresetn(hresetn), .cs_n(i_asr_if.cs_n),
		.read_conv(i_asr_if.read_conv), .tag(i_asr_if.tag),
		.clock_source_sel(i_asr_if.clock_source_sel),
		.busy_n(i_asr_if.busy_n),
		.serial_result_out(i_asr_if.serial_result_out),
		.parallel_result_bus_oe(i_asr_if.parallel_result_bus_oe),
		.serial_bit_clock_dev_oe(i_asr_if.serial_bit_clock_dev_oe),
		.serial_bit_clock(i_asr_if.serial_bit_clock)
	);

	initial hclk = 1'b0;
	always #20 hclk = ~hclk;

	// ==========================================================
	// Checking and closing.
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	function automatic logic [31:0] sat(input logic signed [15:0] v);
		if (v > 16'sh07FF) return 32'h0000_07FF;
		if (v < 16'shF800) return 32'h0000_0800;
		return {20'h0_0000, v[11:0]};
	endfunction

	// ==========================================================
	// Bus master.
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d, input logic c);
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		rd_chk <= c;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
		rd_chk <= 1'b0;
	endtask

	task automatic rd_exp(input logic [31:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 32'h0, 1'b1);
	endtask

	// Oldest note is compared when read data stands.
	always @(posedge hclk) begin
		if (rd_chk) begin
			check("hrdata", hrdata, exp_q.pop_front());
		end
	end

	// Counts bit clock pulses on the wire.
	always @(posedge hclk) begin
		sbc_q <= i_asr_if.serial_bit_clock;
		if (i_asr_if.serial_bit_clock && !sbc_q) pulses <= pulses + 1;
	end

	// One conversion with readout; c selects whether the result is checked.
	task automatic convert(input logic [31:0] ctrl,
		input logic signed [15:0] lv, input logic [31:0] e, input logic c);
		int n;
		xfer(1'b1, 32'h0, ctrl, 1'b0);
		analog_level <= lv;
		pulses = 0;
		xfer(1'b1, 32'h4, 32'h1, 1'b0);
		xfer(1'b1, 32'h4, 32'h1, 1'b0);
		rd = 32'h0;
		n = 0;
		while (rd[1] !== 1'b1 && n < 600) begin
			xfer(1'b0, 32'h8, 32'h0, 1'b0);
			n++;
		end
		rd_exp(32'h8, 32'h6);
		if (c) rd_exp(32'hC, e);
		else xfer(1'b0, 32'hC, 32'h0, 1'b0);
		check("pulses", 32'(pulses), 32'd12);
		check("sdo_z", {31'h0, i_asr_if.serial_result_out === 1'bz}, 32'h0);
	endtask

	// ==========================================================
	// Tests.
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		rd_chk = 1'b0;
		sbc_q = 1'b0;
		analog_level = 16'sh0000;
		n_fail = 0;
		compares = 0;
		pulses = 0;
		void'($urandom(32'hB487));
		lvl = '{16'sh0000, 16'sh7FFF, 16'sh8000, 16'sh07FF, 16'shF800,
			16'sh0800, 16'sh0000};
		lvl[0] = 16'($urandom);
		lvl[6] = 16'($urandom);
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rd_exp(32'h0, 32'h0);
		rd_exp(32'h8, 32'h4);
		xfer(1'b1, 32'h10, 32'hFFFF_FFFF, 1'b0);
		rd_exp(32'h10, 32'h0);
		xfer(1'b1, 32'h0, 32'h2, 1'b0);
		rd_exp(32'h0, 32'h2);
		$display("test registers done");
		for (int i = 0; i < 7; i++) begin
			convert({30'h0, i[0], 1'b0}, lvl[i], sat(lvl[(i + 6) % 7]), i > 0);
		end
		$display("test internal clock done");
		for (int i = 0; i < 7; i++) begin
			convert({30'h0, i[0], 1'b1}, lvl[i], sat(lvl[i]), 1'b1);
		end
		$display("test external clock done");
		give_verdict();
	end

	// Cuts a hang short.
	initial begin
		repeat (30000) @(posedge hclk);
		n_fail++;
		give_verdict();
	end
endmodule
`default_nettype wire

// *** dv/asr_chk.sv ***
// Concurrent checks on the pins between the converter and its controller.
`timescale 1ns/1ps
`default_nettype none
module asr_chk (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Controller to converter.
	input wire logic cs_n,
	input wire logic read_conv,
	input wire logic clock_source_sel,
	input wire logic tag,
	// Converter to controller, and the shared bit clock wire.
	input wire logic busy_n,
	input wire logic serial_result_out,
	input wire logic parallel_result_bus_oe,
	input wire logic serial_bit_clock_dev_oe,
	input wire logic serial_bit_clock
);
	logic [8:0] low_q;
	logic [3:0] rise_q;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// ==========================================================
	// Counts cycles since busy fell and internal pulses since then.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_q  <= 9'h000;
			rise_q <= 4'h0;
		end else if ($fell(busy_n)) begin
			low_q  <= 9'h000;
			rise_q <= 4'h0;
		end else begin
			if (low_q != 9'h1FF) begin
				low_q <= low_q + 9'h001;
			end
			if ($rose(serial_bit_clock) && !clock_source_sel && rise_q != 4'hF) begin
				rise_q <= rise_q + 4'h1;
			end
		end
	end

	// ==========================================================
	// Assertions.
	par_off_a: assert property (cs_n [*4] |-> !parallel_result_bus_oe)
		else $error("parallel bus driven while deselected");
	par_on_a: assert property ((!cs_n && read_conv) [*4] |-> parallel_result_bus_oe)
		else $error("parallel bus not driven while read selected");
	conv_start_a: assert property (!cs_n && !read_conv && busy_n |-> ##[1:6] !busy_n)
		else $error("convert command did not start a conversion");
	pulse_count_a: assert property ($rose(busy_n) && !clock_source_sel |-> rise_q == 4'hC)
		else $error("internal clock pulse count wrong");
	int_stable_a: assert property ($rose(serial_bit_clock) && !clock_source_sel |-> ($stable(serial_result_out)) [*8])
		else $error("serial data moved during internal clock high");
	// The reloaded result may show in the one cycle before busy rises.
	tag_level_a: assert property (rise_q == 4'hC && !clock_source_sel &&
		!busy_n && !serial_bit_clock && !$past(serial_bit_clock) &&
		!$past(serial_bit_clock, 2) |->
		(serial_result_out == tag) or (##1 busy_n))
		else $error("serial output not at tag level after last pulse");
	dev_clk_off_a: assert property (clock_source_sel [*4] |-> !serial_bit_clock_dev_oe)
		else $error("converter drives bit clock in external mode");
	busy_len_a: assert property ($rose(busy_n) |-> low_q >= 9'd360 && low_q <= 9'd375)
		else $error("busy low time wrong");
	ext_stable_a: assert property ($fell(serial_bit_clock) && clock_source_sel && !cs_n && read_conv |-> ($stable(serial_result_out)) [*6])
		else $error("serial data moved around external falling edge");
	first_pulse_a: assert property ($rose(serial_bit_clock) && !clock_source_sel && rise_q == 4'h0 |-> low_q >= 9'd28 && low_q <= 9'd40)
		else $error("first internal pulse out of place");
endmodule
`default_nettype wire

// *** rtl/asr_consts.svh ***
// Shared constants for the serial readout converter and its controller.
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH
// ==========================================================
// Clock and timing.
`define ASR_CLK_NS        40
`define ASR_CONV_NS       14700
`define ASR_DCLK_DLY_NS   1400
`define ASR_DCLK_PER_NS   1100
`define ASR_CPULSE_NS     160
`define ASR_EXT_HI_CYC    8
`define ASR_EXT_LO_CYC    4
// ==========================================================
// Result format.
`define ASR_RES_W         12
`define ASR_IN_W          16
`define ASR_PAR_W         8
`define ASR_LSB_NIB       4
// ==========================================================
// Controller register byte offsets.
`define ASR_A_CTRL        4'h0
`define ASR_A_CMD         4'h4
`define ASR_A_STATUS      4'h8
`define ASR_A_RESULT      4'hC
// ==========================================================
// Controller register fields and reset values.
`define ASR_CTRL_EXT      0
`define ASR_CTRL_TAG      1
`define ASR_CMD_START     0
`define ASR_ST_RUN        0
`define ASR_ST_DONE       1
`define ASR_ST_PBUSY      2
`define ASR_CTRL_RST      2'h0
`endif

// *** rtl/asr_device.sv ***
// Converter end: conversion timing, result register and serial readout.
// How it works
// R01 - Parallel bus driven when select low, read high.
// R02 - Serial output is always driven.
// R03 - Internal mode: both low starts, clock runs.
// R04 - Twelve previous-result bits MSB first, twelve pulses.
// R05 - Internal bits stable across each pulse.
// R06 - After pulse twelve clock low, output tag.
// R07 - External mode: pin is input, shifts only.
// R08 - Host holds select low, read high to read.
// R09 - Host clock high 20-70 percent, up to 10MHz.
// R10 - Host clock period 100ns, low 40, high 50.
// R11 - External read after or during next conversion.
// R12 - Busy rises only after result register loads.
// R13 - Host keeps read or clock low near load.
// R14 - MSB at fall 1, LSB at fall 12.
// R15 - One tag per pulse; first at fall 13.
// R16 - Tag keeps flowing until next reload.
// R17 - Host reads nothing from 12us until busy rises.
// R18 - Host preferably keeps clock quiet during conversion.
// R19 - First pulse after 1.4us, period 1.1us. Here the period is 27 cycles, 1.08us.
// R20 - Out of range saturates, never wraps.
// R21 - Convert commands ignored while busy low.
// R22 - Each pulse shifts once; parallel read does not. Here the first external pulse only loads the tag and does not shift.
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "asr_consts.svh"
module asr_device #(
	parameter int RES_W = `ASR_RES_W,
	parameter int IN_W  = `ASR_IN_W
) (
	// Clock and reset.
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	// Level to be converted.
	input  wire logic signed [IN_W-1:0] analog_level,
	// Pins.
	asr_if.dev                          pins
);
	localparam int CONV_CYC = `ASR_CONV_NS / `ASR_CLK_NS;
	localparam int DLY_CYC  = `ASR_DCLK_DLY_NS / `ASR_CLK_NS;
	localparam int PER_CYC  = `ASR_DCLK_PER_NS / `ASR_CLK_NS;
	localparam int HI_CYC   = PER_CYC / 2;
	localparam int LO_CYC   = PER_CYC - HI_CYC;
	localparam int NS       = 6;
	localparam logic signed [IN_W-1:0] MAXV =
		IN_W'((1 << (RES_W - 1)) - 1);
	localparam logic signed [IN_W-1:0] MINV =
		IN_W'(-(1 << (RES_W - 1)));

	// ==========================================================
	// Input synchronisers.
	logic [NS-1:0] raw;
	logic [NS-1:0] s1_q;
	logic [NS-1:0] s2_q;
	logic [NS-1:0] p_q;

	assign raw = {pins.cs_n, pins.read_conv, pins.clock_source_sel,
		pins.byte_sel, pins.tag, pins.serial_bit_clock};

	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++) begin : g_sync
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					s1_q[gi] <= 1'b1;
					s2_q[gi] <= 1'b1;
					p_q[gi]  <= 1'b1;
				end else begin
					s1_q[gi] <= raw[gi];
					s2_q[gi] <= s1_q[gi];
					p_q[gi]  <= s2_q[gi];
				end
			end
		end
	endgenerate

	logic cs_s;
	logic rc_s;
	logic ext_s;
	logic bsel_s;
	logic tag_s;
	logic clk_s;
	logic clk_p;
	logic cmd_p;

	assign cs_s   = s2_q[5];
	assign rc_s   = s2_q[4];
	assign ext_s  = s2_q[3];
	assign bsel_s = s2_q[2];
	assign tag_s  = s2_q[1];
	assign clk_s  = s2_q[0];
	assign clk_p  = p_q[0];
	assign cmd_p  = !p_q[5] && !p_q[4];

	// ==========================================================
	// Conversion sequencing.
	asr_pkg::asr_dstate_type st_q;
	logic [8:0]              conv_cnt_q;
	logic [RES_W-1:0]        sample_q;
	logic                    busy_n_q;
	logic                    start;
	logic                    load;

	function automatic logic [RES_W-1:0] saturate(
		input logic signed [IN_W-1:0] v);
		if (v > MAXV)
			saturate = {1'b0, {(RES_W-1){1'b1}}}; // [R20]
		else if (v < MINV)
			saturate = {1'b1, {(RES_W-1){1'b0}}}; // [R20]
		else
			saturate = v[RES_W-1:0];
	endfunction

	// A new command is the moment select and read both become low.
	assign start = !cs_s && !rc_s && !cmd_p &&
		(st_q == asr_pkg::DS_IDLE); // [R03] [R21]
	assign load  = (st_q == asr_pkg::DS_CONV) && (conv_cnt_q == 9'h000);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q       <= asr_pkg::DS_IDLE;
			conv_cnt_q <= 9'h000;
		end else begin
			unique case (st_q)
				asr_pkg::DS_IDLE: begin
					if (start) begin
						st_q       <= asr_pkg::DS_CONV;
						conv_cnt_q <= 9'(CONV_CYC - 1);
					end
				end
				asr_pkg::DS_CONV: begin
					if (conv_cnt_q == 9'h000)
						st_q <= asr_pkg::DS_LOAD;
					else
						conv_cnt_q <= conv_cnt_q - 9'h001;
				end
				asr_pkg::DS_LOAD: begin
					st_q <= asr_pkg::DS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			sample_q <= '0;
		else if (start)
			sample_q <= saturate(analog_level); // [R20]
	end

	// Busy rises the cycle after the result register is loaded.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			busy_n_q <= 1'b1;
		else if (start)
			busy_n_q <= 1'b0;
		else if (st_q == asr_pkg::DS_LOAD)
			busy_n_q <= 1'b1; // [R12]
	end

	// ==========================================================
	// Internal data clock generator.
	logic       ic_on_q;
	logic       ic_q;
	logic [5:0] ic_cnt_q;
	logic [3:0] ic_n_q;
	logic       ic_rise;
	logic       ic_fall;

	assign ic_rise = ic_on_q && (ic_cnt_q == 6'h00) && !ic_q;
	assign ic_fall = ic_on_q && (ic_cnt_q == 6'h00) && ic_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ic_on_q  <= 1'b0;
			ic_q     <= 1'b0;
			ic_cnt_q <= 6'h00;
			ic_n_q   <= 4'h0;
		end else if (start && !ext_s) begin
			ic_on_q  <= 1'b1; // [R03]
			ic_q     <= 1'b0;
			ic_cnt_q <= 6'(DLY_CYC - 1); // [R19]
			ic_n_q   <= 4'h0;
		end else if (ic_rise) begin
			ic_q     <= 1'b1;
			ic_cnt_q <= 6'(HI_CYC - 1); // [R19]
		end else if (ic_fall) begin
			ic_q     <= 1'b0;
			ic_cnt_q <= 6'(LO_CYC - 1); // [R19]
			ic_n_q   <= ic_n_q + 4'h1;
			if (ic_n_q == 4'(`ASR_RES_W - 1))
				ic_on_q <= 1'b0; // [R04] [R06]
		end else if (ic_on_q) begin
			ic_cnt_q <= ic_cnt_q - 6'h01;
		end
	end

	// ==========================================================
	// Output shift register and tag chain.
	logic [RES_W-1:0] srg_q;
	logic             pend_q;
	logic             first_q;
	logic             ext_en;
	logic             ext_rise;

	// External edges count only in output mode with the pin as input.
	assign ext_en   = ext_s && !cs_s && rc_s; // [R07] [R08]
	assign ext_rise = ext_en && clk_s && !clk_p;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			srg_q   <= '0;
			pend_q  <= 1'b0;
			first_q <= 1'b0;
		end else if (load) begin
			srg_q   <= sample_q; // [R11] [R16]
			first_q <= 1'b0;
		end else if (ext_rise) begin
			pend_q <= tag_s; // [R15]
			if (first_q)
				srg_q <= {srg_q[RES_W-2:0], pend_q}; // [R14] [R22]
			else
				first_q <= 1'b1; // [R14]
		end else if (ic_rise && (ic_n_q == 4'h0)) begin
			pend_q <= tag_s; // [R06]
		end else if (ic_fall) begin
			srg_q <= {srg_q[RES_W-2:0], pend_q}; // [R05] [R06] [R22]
		end
	end

	// ==========================================================
	// Pin drivers.
	logic       par_oe_q;
	logic [7:0] par_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			par_oe_q <= 1'b0;
			par_q    <= 8'h00;
		end else begin
			par_oe_q <= !cs_s && rc_s; // [R01]
			if (bsel_s)
				par_q <= {srg_q[`ASR_LSB_NIB-1:0], 4'h0}; // [R22]
			else
				par_q <= srg_q[RES_W-1 -: `ASR_PAR_W]; // [R22]
		end
	end

	assign pins.parallel_result_bus_o   = par_q;
	assign pins.parallel_result_bus_oe  = par_oe_q; // [R01]
	assign pins.serial_result_out       = srg_q[RES_W-1]; // [R02]
	assign pins.busy_n                  = busy_n_q;
	assign pins.serial_bit_clock_dev_o  = ic_q; // [R06]
	assign pins.serial_bit_clock_dev_oe = !ext_s; // [R07]
endmodule
`default_nettype wire

// *** rtl/asr_host.sv ***
// Controller end: AHB-Lite registers, convert pulse and serial capture.
`timescale 1ns/1ps
`default_nettype none
`include "asr_consts.svh"
module asr_host #(
	parameter int RES_W  = `ASR_RES_W,
	parameter int HI_CYC = `ASR_EXT_HI_CYC,
	parameter int LO_CYC = `ASR_EXT_LO_CYC
) (
	// Clock and reset.
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Pins.
	asr_if.host              pins
);
	localparam int PULSE_CYC = `ASR_CPULSE_NS / `ASR_CLK_NS;

	// ==========================================================
	// Pin synchronisers: busy, data, clock.
	logic [2:0] s1_q;
	logic [2:0] s2_q;
	logic [2:0] p_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= 3'h7;
			s2_q <= 3'h7;
			p_q  <= 3'h7;
		end else begin
			s1_q <= {pins.busy_n, pins.serial_result_out,
				pins.serial_bit_clock};
			s2_q <= s1_q;
			p_q  <= s2_q;
		end
	end

	// ==========================================================
	// Register bus.
	logic [1:0]       ctrl_q;
	logic             done_q;
	logic [RES_W-1:0] result_q;
	logic [3:0]       addr_q;
	logic             wr_q;
	logic [31:0]      rdata_q;
	logic             acc;
	logic             mapped;
	logic             start;
	logic             run;
	logic             finish;
	logic [31:0]      rd_mux;

	assign acc   = hsel && htrans[1] && hready;
	// Offsets beyond the register block read zero and ignore writes.
	assign mapped = (haddr[31:4] == 28'h000_0000);
	assign start = wr_q && (addr_q == `ASR_A_CMD) && hwdata[`ASR_CMD_START];

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (haddr[3:0])
			`ASR_A_CTRL:   rd_mux[1:0] = ctrl_q;
			`ASR_A_STATUS: rd_mux[2:0] = {s2_q[2], done_q, run};
			`ASR_A_RESULT: rd_mux[RES_W-1:0] = result_q;
			default:       rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q  <= 4'h0;
			wr_q    <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			wr_q <= acc && hwrite && mapped;
			if (acc)
				addr_q <= haddr[3:0];
			if (acc && !hwrite)
				rdata_q <= mapped ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ctrl_q <= `ASR_CTRL_RST;
		else if (wr_q && (addr_q == `ASR_A_CTRL))
			ctrl_q <= hwdata[1:0];
	end

	// Done is set on completion; setting wins over the clearing start.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			done_q <= 1'b0;
		else if (finish)
			done_q <= 1'b1;
		else if (start)
			done_q <= 1'b0;
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;

	// ==========================================================
	// Conversion and readout sequencer.
	asr_pkg::asr_hstate_type st_q;
	logic [7:0]              cnt_q;
	logic [3:0]              n_q;
	logic [RES_W-1:0]        shr_q;
	logic                    cs_n_q;
	logic                    rc_q;
	logic                    hc_q;
	logic                    ext;
	logic                    busy_rise;

	assign ext       = ctrl_q[`ASR_CTRL_EXT];
	assign run       = (st_q != asr_pkg::HS_IDLE);
	assign busy_rise = s2_q[2] && !p_q[2];
	assign finish    = (st_q == asr_pkg::HS_WHIGH && busy_rise && !ext) ||
		(st_q == asr_pkg::HS_EXT && hc_q && cnt_q == 8'h00 &&
		n_q == 4'(RES_W - 1));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q   <= asr_pkg::HS_IDLE;
			cnt_q  <= 8'h00;
			n_q    <= 4'h0;
			cs_n_q <= 1'b1;
			rc_q   <= 1'b1;
			hc_q   <= 1'b0;
			shr_q  <= '0;
		end else begin
			unique case (st_q)
				asr_pkg::HS_IDLE: begin
					if (start) begin
						st_q   <= asr_pkg::HS_PULSE;
						cnt_q  <= 8'(PULSE_CYC - 1);
						n_q    <= 4'h0;
						cs_n_q <= 1'b0;
						rc_q   <= 1'b0;
					end
				end
				asr_pkg::HS_PULSE: begin
					if (cnt_q == 8'h00) begin
						st_q   <= asr_pkg::HS_WLOW;
						cs_n_q <= 1'b1; // [R13]
						rc_q   <= 1'b1;
					end else
						cnt_q <= cnt_q - 8'h01;
				end
				asr_pkg::HS_WLOW: begin
					if (!s2_q[2])
						st_q <= asr_pkg::HS_WHIGH;
				end
				asr_pkg::HS_WHIGH: begin
					// Internal bits are caught on rising clock edges.
					if (!ext && s2_q[0] && !p_q[0] && n_q != 4'(RES_W)) begin
						shr_q <= {shr_q[RES_W-2:0], s2_q[1]};
						n_q   <= n_q + 4'h1;
					end
					if (busy_rise) begin
						n_q <= 4'h0;
						if (ext) begin
							st_q   <= asr_pkg::HS_EXT; // [R17] [R18]
							cs_n_q <= 1'b0; // [R08]
							cnt_q  <= 8'(LO_CYC - 1);
						end else begin
							st_q <= asr_pkg::HS_IDLE;
						end
					end
				end
				asr_pkg::HS_EXT: begin
					if (cnt_q != 8'h00)
						cnt_q <= cnt_q - 8'h01;
					else if (!hc_q) begin
						hc_q  <= 1'b1;
						cnt_q <= 8'(HI_CYC - 1); // [R09] [R10]
					end else begin
						hc_q  <= 1'b0;
						cnt_q <= 8'(LO_CYC - 1); // [R09] [R10]
						shr_q <= {shr_q[RES_W-2:0], s2_q[1]};
						n_q   <= n_q + 4'h1;
						if (n_q == 4'(RES_W - 1)) begin
							st_q   <= asr_pkg::HS_IDLE;
							cs_n_q <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			result_q <= '0;
		else if (finish && st_q == asr_pkg::HS_EXT)
			result_q <= {shr_q[RES_W-2:0], s2_q[1]};
		else if (finish)
			result_q <= shr_q;
	end

	assign pins.cs_n                     = cs_n_q;
	assign pins.read_conv                = rc_q;
	assign pins.clock_source_sel         = ext;
	assign pins.byte_sel                 = 1'b0;
	assign pins.tag                      = ctrl_q[`ASR_CTRL_TAG];
	assign pins.serial_bit_clock_host_o  = hc_q;
	assign pins.serial_bit_clock_host_oe = ext; // [R07]
endmodule
`default_nettype wire

// *** rtl/asr_if.sv ***
// Pin bundle between the converter readout and its controller.
`timescale 1ns/1ps
`default_nettype none
interface asr_if;
	logic       cs_n;
	logic       read_conv;
	logic       clock_source_sel;
	logic       byte_sel;
	logic       tag;
	logic       busy_n;
	logic       serial_result_out;
	logic [7:0] parallel_result_bus_o;
	logic       parallel_result_bus_oe;
	logic [7:0] parallel_result_bus;
	logic       serial_bit_clock_dev_o;
	logic       serial_bit_clock_dev_oe;
	logic       serial_bit_clock_host_o;
	logic       serial_bit_clock_host_oe;
	logic       serial_bit_clock;

	// ==========================================================
	// Wire levels worked out from the drivers' enables.
	assign serial_bit_clock = serial_bit_clock_dev_oe ? serial_bit_clock_dev_o
		: (serial_bit_clock_host_oe & serial_bit_clock_host_o);
	assign parallel_result_bus = parallel_result_bus_oe ?
		parallel_result_bus_o : 8'h00;

	modport dev (
		input  cs_n, read_conv, clock_source_sel, byte_sel, tag,
		input  serial_bit_clock,
		output busy_n, serial_result_out,
		output parallel_result_bus_o, parallel_result_bus_oe,
		output serial_bit_clock_dev_o, serial_bit_clock_dev_oe
	);
	modport host (
		output cs_n, read_conv, clock_source_sel, byte_sel, tag,
		output serial_bit_clock_host_o, serial_bit_clock_host_oe,
		input  busy_n, serial_result_out, parallel_result_bus,
		input  serial_bit_clock
	);
endinterface
`default_nettype wire

// *** rtl/asr_pkg.sv ***
// Types shared by the converter readout and its controller.
package asr_pkg;
	typedef enum logic [1:0] {DS_IDLE, DS_CONV, DS_LOAD} asr_dstate_type;
	typedef enum logic [2:0] {
		HS_IDLE, HS_PULSE, HS_WLOW, HS_WHIGH, HS_EXT
	} asr_hstate_type;
endpackage
